// >>> src/ocr_regs.sv
// serial-bus register bank of the programmable oscillator
// Overview of operation
// R1 - address zero reads a fixed part code; writes do nothing
// R2 - writing one to bit 7 of register 7 resets device; bit reads zero
// R3 - writing one to bit 3 of register 7 starts calibration; self clears
// R4 - override bit zero forces output off; one hands control to pin
// R5 - fast divider is 11 bits: reg 23 low, reg 24 bits 2:0 high
// R6 - host keeps fast divider 5..2046, even above 33
// R7 - power-of-two code 0..7 gives ratios 1,2,4,8,16,32,32,32
// R8 - feedback ratio is 11.32 fixed point over registers 26..31
// R9 - host keeps feedback integer part between 60 and 2045
// R10 - bypass bit set skips calibration; clear lets it run
// R11 - fine offset is 24-bit two's complement frequency step word
// R12 - host keeps fine offset within -8161513..+8161512
// R13 - fine offset takes effect only when register 233 is written
// R14 - host writes fine offset bytes 231, 232, then 233
// R15 - page bits in register 255 form address bits 9:8
// R16 - effective address is page times 256 plus bus address
// R17 - host changes frequency in the fixed page/bypass/disable/cal order
// R18 - host starts calibration with 0x08 to register 7, waits 30 ms
// R19 - new fine offset is applied in one step, without glitches
// R20 - unused bits of registers 17, 24, 31 read zero, writes ignored
// R21 - host preserves reserved bits of registers 69 and 255
`timescale 1ns/1ns
module ocr_regs #(
    parameter logic [6:0]  BUS_ADDR   = ocr_pkg::DEF_BUS_ADDR,
    parameter logic [7:0]  PART_CODE  = ocr_pkg::DEF_PART_CODE,
    parameter int unsigned CAL_CYCLES = ocr_pkg::CAL_CYCLES
) (
    input  wire logic                        i_clk_sys,
    input  wire logic                        i_nrst,
    input  wire logic                        i_scl,
    input  wire logic                        i_sda,
    output logic                             o_sda_out,
    output logic                             o_sda_oe,
    input  wire logic                        i_output_enable_n,
    output logic                             o_clk_enable,
    output logic                             o_output_override_enable,
    output logic [ocr_pkg::FAST_W-1:0]       o_fast_output_divider,
    output logic [ocr_pkg::P2_W-1:0]         o_power_of_two_divider,
    output logic [5:0]                       o_power_of_two_ratio,
    output logic [ocr_pkg::FB_W-1:0]         o_feedback_ratio,
    output logic                             o_calibration_bypass,
    output logic                             o_calibration_start,
    output logic                             o_calibration_busy,
    output logic [ocr_pkg::FINE_W-1:0]       o_fine_frequency_offset,
    output logic                             o_fine_offset_load,
    output logic                             o_device_reset,
    output logic [ocr_pkg::PAGE_W-1:0]       o_page
);
    import ocr_pkg::*;

    localparam int CAL_W = $clog2(CAL_CYCLES + 1);

    if (CAL_CYCLES < 1 || CAL_W > 31) begin : g_bad_cal
        $error("calibration cycle count out of range");
    end

    // ratio 2**code, clipped at 32
    function automatic logic [5:0] p2_ratio(input logic [P2_W-1:0] code);
        logic [P2_W-1:0] c;
        c = (code > P2_MAX_CODE) ? P2_MAX_CODE : code;
        return 6'(6'h01 << c);
    endfunction

    // pin synchronisers
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic [1:0] oe_n_sync;
    logic       scl_q;
    logic       sda_q;

    always_ff @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            scl_sync  <= 2'h3;
            sda_sync  <= 2'h3;
            oe_n_sync <= 2'h3;
            scl_q     <= 1'b1;
            sda_q     <= 1'b1;
        end else begin
            scl_sync  <= {scl_sync[0], i_scl};
            sda_sync  <= {sda_sync[0], i_sda};
            oe_n_sync <= {oe_n_sync[0], i_output_enable_n};
            scl_q     <= scl_sync[1];
            sda_q     <= sda_sync[1];
        end
    end

    wire scl        = scl_sync[1];
    wire sda        = sda_sync[1];
    wire scl_rise   = scl & ~scl_q;
    wire scl_fall   = ~scl & scl_q;
    wire start_cond = scl & scl_q & sda_q & ~sda;
    wire stop_cond  = scl & scl_q & ~sda_q & sda;

    // protocol state
    ocr_state_type state;
    ocr_state_type next_state;
    logic [2:0]    bit_cnt;
    logic [2:0]    next_bit_cnt;
    logic [7:0]    shreg;
    logic [7:0]    next_shreg;
    logic [7:0]    ptr;
    logic [7:0]    next_ptr;
    logic          full;
    logic          next_full;
    logic          nack;
    logic          next_nack;
    logic          next_sda_oe;
    logic          wr_stb;
    logic [7:0]    rd_data;

    // register bank
    logic [7:0]        fine_stage0;
    logic [7:0]        fine_stage1;
    logic [CAL_W-1:0]  cal_cnt;

    wire [9:0] eff_addr  = {o_page, ptr}; // R15 R16
    wire       page_zero = (o_page == 2'h0);
    wire       sel_page  = (ptr == ADDR_PAGE);
    wire       wr_pg0    = wr_stb & page_zero;
    wire       w_ctrl    = wr_pg0 & (ptr == ADDR_CTRL);
    wire       cal_go    = w_ctrl & shreg[CTRL_CAL_BIT]
                           & ~o_calibration_bypass & ~o_calibration_busy;
    wire       fine_go   = wr_pg0 & (ptr == ADDR_FINE2);

    always_comb begin
        next_state   = state;
        next_bit_cnt = bit_cnt;
        next_shreg   = shreg;
        next_ptr     = ptr;
        next_full    = full;
        next_nack    = nack;
        next_sda_oe  = o_sda_oe;
        wr_stb       = 1'b0;
        if (start_cond) begin
            next_state   = S_DEV;
            next_bit_cnt = 3'h0;
            next_full    = 1'b0;
            next_sda_oe  = 1'b0;
        end else if (stop_cond) begin
            next_state  = S_IDLE;
            next_sda_oe = 1'b0;
        end else if (scl_rise) begin
            unique case (state)
                S_DEV, S_PTR, S_WR: begin
                    next_shreg   = {shreg[6:0], sda};
                    next_bit_cnt = 3'(bit_cnt + 3'h1);
                    next_full    = (bit_cnt == 3'h7);
                end
                S_RD_ACK: next_nack = sda;
                default: ;
            endcase
        end else if (scl_fall) begin
            unique case (state)
                S_IDLE: ;
                S_DEV: if (full) begin
                    next_full = 1'b0;
                    if (shreg[7:1] == BUS_ADDR) begin
                        next_state  = S_DEV_ACK;
                        next_sda_oe = 1'b1;
                    end else begin
                        next_state = S_IDLE;
                    end
                end
                S_DEV_ACK: if (shreg[0]) begin
                    next_state   = S_RD;
                    next_shreg   = rd_data;
                    next_sda_oe  = ~rd_data[7];
                    next_bit_cnt = 3'h0;
                    next_ptr     = 8'(ptr + 8'h01);
                end else begin
                    next_state  = S_PTR;
                    next_sda_oe = 1'b0;
                end
                S_PTR: if (full) begin
                    next_full   = 1'b0;
                    next_ptr    = shreg;
                    next_sda_oe = 1'b1;
                    next_state  = S_PTR_ACK;
                end
                S_PTR_ACK: begin
                    next_sda_oe = 1'b0;
                    next_state  = S_WR;
                end
                S_WR: if (full) begin
                    next_full   = 1'b0;
                    wr_stb      = 1'b1;
                    next_sda_oe = 1'b1;
                    next_state  = S_WR_ACK;
                end
                S_WR_ACK: begin
                    next_sda_oe = 1'b0;
                    next_ptr    = 8'(ptr + 8'h01);
                    next_state  = S_WR;
                end
                S_RD: if (bit_cnt == 3'h7) begin
                    next_sda_oe = 1'b0;
                    next_state  = S_RD_ACK;
                end else begin
                    next_bit_cnt = 3'(bit_cnt + 3'h1);
                    next_shreg   = {shreg[6:0], 1'b0};
                    next_sda_oe  = ~shreg[6];
                end
                S_RD_ACK: if (nack) begin
                    next_state = S_IDLE;
                end else begin
                    next_state   = S_RD;
                    next_shreg   = rd_data;
                    next_sda_oe  = ~rd_data[7];
                    next_bit_cnt = 3'h0;
                    next_ptr     = 8'(ptr + 8'h01);
                end
            endcase
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            state     <= S_IDLE;
            bit_cnt   <= 3'h0;
            shreg     <= 8'h00;
            ptr       <= 8'h00;
            full      <= 1'b0;
            nack      <= 1'b1;
            o_sda_oe  <= 1'b0;
            o_sda_out <= 1'b0;
        end else begin
            state     <= next_state;
            bit_cnt   <= next_bit_cnt;
            shreg     <= next_shreg;
            ptr       <= next_ptr;
            full      <= next_full;
            nack      <= next_nack;
            o_sda_oe  <= next_sda_oe;
            o_sda_out <= 1'b0;
        end
    end

    // read mux; register 7 always reads zero since both bits self clear
    always_comb begin
        rd_data = 8'h00;
        if (sel_page) begin
            rd_data = {6'h00, o_page}; // R15
        end else if (page_zero) begin
            unique case (eff_addr[7:0])
                ADDR_ID:      rd_data = PART_CODE; // R1
                ADDR_CTRL:    rd_data = 8'h00; // R2 R3
                ADDR_OUT: rd_data = {7'h00, o_output_override_enable}; // R20
                ADDR_FAST_LO: rd_data = o_fast_output_divider[7:0];
                ADDR_PACKED:  rd_data = {1'b0, o_power_of_two_divider,
                                         1'b0, o_fast_output_divider[10:8]};
                ADDR_FB0:     rd_data = o_feedback_ratio[7:0];
                ADDR_FB1:     rd_data = o_feedback_ratio[15:8];
                ADDR_FB2:     rd_data = o_feedback_ratio[23:16];
                ADDR_FB3:     rd_data = o_feedback_ratio[31:24];
                ADDR_FB4:     rd_data = o_feedback_ratio[39:32];
                ADDR_FB_TOP:  rd_data = {5'h00, o_feedback_ratio[42:40]};
                ADDR_BYPASS:  rd_data = {o_calibration_bypass, BYPASS_RSVD};
                ADDR_FINE0:   rd_data = fine_stage0;
                ADDR_FINE1:   rd_data = fine_stage1;
                ADDR_FINE2:   rd_data = o_fine_frequency_offset[23:16];
                default:      rd_data = 8'h00;
            endcase
        end
    end

    // a soft reset restores the bank one cycle after the write
    always_ff @(posedge i_clk_sys) begin
        if (!i_nrst || o_device_reset) begin // R2
            o_output_override_enable <= RST_OVERRIDE; // R4
            o_fast_output_divider    <= RST_FAST;
            o_power_of_two_divider   <= RST_P2;
            o_feedback_ratio         <= RST_FB;
            o_calibration_bypass     <= RST_BYPASS;
            fine_stage0              <= 8'h00;
            fine_stage1              <= 8'h00;
            o_fine_frequency_offset  <= '0;
            o_page                   <= 2'h0;
        end else if (wr_stb) begin
            if (sel_page) begin
                o_page <= shreg[1:0]; // R15
            end
            if (page_zero) begin
                unique case (ptr)
                    ADDR_OUT: o_output_override_enable <= shreg[OUT_EN_BIT];
                    ADDR_FAST_LO: o_fast_output_divider[7:0] <= shreg; // R5
                    ADDR_PACKED: begin
                        o_fast_output_divider[10:8] <= shreg[2:0]; // R5
                        o_power_of_two_divider <=
                            shreg[PACKED_P2_LSB +: P2_W]; // R20
                    end
                    ADDR_FB0:    o_feedback_ratio[7:0]   <= shreg; // R8
                    ADDR_FB1:    o_feedback_ratio[15:8]  <= shreg;
                    ADDR_FB2:    o_feedback_ratio[23:16] <= shreg;
                    ADDR_FB3:    o_feedback_ratio[31:24] <= shreg;
                    ADDR_FB4:    o_feedback_ratio[39:32] <= shreg;
                    ADDR_FB_TOP: o_feedback_ratio[42:40] <= shreg[2:0]; // R20
                    ADDR_BYPASS: o_calibration_bypass <= shreg[BYPASS_BIT];
                    ADDR_FINE0:  fine_stage0 <= shreg; // R13
                    ADDR_FINE1:  fine_stage1 <= shreg; // R13
                    // whole word lands in one edge, never a torn value
                    ADDR_FINE2:  o_fine_frequency_offset <= // R11 R13 R19
                                     {shreg, fine_stage1, fine_stage0};
                    default: ;
                endcase
            end
        end
    end

    // pulses, calibration timer and output gating
    always_ff @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            o_device_reset       <= 1'b0;
            o_calibration_start  <= 1'b0;
            o_calibration_busy   <= 1'b0;
            cal_cnt              <= '0;
            o_fine_offset_load   <= 1'b0;
            o_clk_enable         <= 1'b0;
            o_power_of_two_ratio <= 6'h01;
        end else begin
            o_device_reset      <= w_ctrl & shreg[CTRL_RESET_BIT]; // R2
            o_calibration_start <= cal_go; // R3 R10
            o_fine_offset_load  <= fine_go & ~o_device_reset; // R13
            if (cal_go) begin
                cal_cnt            <= CAL_W'(CAL_CYCLES); // R18
                o_calibration_busy <= 1'b1;
            end else if (o_device_reset) begin
                cal_cnt            <= '0;
                o_calibration_busy <= 1'b0;
            end else if (cal_cnt != '0) begin
                cal_cnt            <= CAL_W'(cal_cnt - 1'b1);
                o_calibration_busy <= (cal_cnt != CAL_W'(1));
            end
            o_clk_enable <= o_output_override_enable & ~oe_n_sync[1]; // R4
            o_power_of_two_ratio <= p2_ratio(o_power_of_two_divider); // R7
        end
    end
endmodule

// >>> inc/ocr_pkg.sv
// constants for the oscillator control register bank
package ocr_pkg;
    // register offsets within a page
    localparam logic [7:0] ADDR_ID      = 8'h00;
    localparam logic [7:0] ADDR_CTRL    = 8'h07;
    localparam logic [7:0] ADDR_OUT     = 8'h11;
    localparam logic [7:0] ADDR_FAST_LO = 8'h17;
    localparam logic [7:0] ADDR_PACKED  = 8'h18;
    localparam logic [7:0] ADDR_FB0     = 8'h1a;
    localparam logic [7:0] ADDR_FB1     = 8'h1b;
    localparam logic [7:0] ADDR_FB2     = 8'h1c;
    localparam logic [7:0] ADDR_FB3     = 8'h1d;
    localparam logic [7:0] ADDR_FB4     = 8'h1e;
    localparam logic [7:0] ADDR_FB_TOP  = 8'h1f;
    localparam logic [7:0] ADDR_BYPASS  = 8'h45;
    localparam logic [7:0] ADDR_FINE0   = 8'he7;
    localparam logic [7:0] ADDR_FINE1   = 8'he8;
    localparam logic [7:0] ADDR_FINE2   = 8'he9;
    localparam logic [7:0] ADDR_PAGE    = 8'hff;

    // field positions
    localparam int CTRL_RESET_BIT = 7;
    localparam int CTRL_CAL_BIT   = 3;
    localparam int OUT_EN_BIT     = 0;
    localparam int PACKED_P2_LSB  = 4;
    localparam int BYPASS_BIT     = 7;

    // field widths
    localparam int FAST_W = 11;
    localparam int P2_W   = 3;
    localparam int FB_W   = 43;
    localparam int FINE_W = 24;
    localparam int PAGE_W = 2;

    // reset values, reserved bits of register 69 and ratio clip code
    localparam logic             RST_OVERRIDE = 1'b1;
    localparam logic [FAST_W-1:0] RST_FAST    = 11'h054;
    localparam logic [P2_W-1:0]   RST_P2      = 3'h0;
    localparam logic [FB_W-1:0]   RST_FB      = 43'h06400000000;
    localparam logic             RST_BYPASS   = 1'b1;
    localparam logic [6:0]        BYPASS_RSVD = 7'h01;
    localparam logic [P2_W-1:0]   P2_MAX_CODE = 3'h5;

    // timing
    localparam int unsigned CAL_TIME_US = 30000;
    localparam int unsigned SYS_CLK_MHZ = 100;
    localparam int unsigned CAL_CYCLES  = CAL_TIME_US * SYS_CLK_MHZ;

    // bus address and part code; both values are arbitrary
    localparam logic [6:0] DEF_BUS_ADDR  = 7'h55;
    localparam logic [7:0] DEF_PART_CODE = 8'h3c;

    typedef enum logic [3:0] {
        S_IDLE, S_DEV, S_DEV_ACK, S_PTR, S_PTR_ACK,
        S_WR, S_WR_ACK, S_RD, S_RD_ACK
    } ocr_state_type;
endpackage

// >>> verification/ocr_regs_assertions.sv
// assertion checker for the oscillator register bank
`timescale 1ns/1ns
module ocr_regs_assertions #(
    parameter int unsigned CAL_CYCLES = 50
) (
    input wire logic                       i_clk_sys,
    input wire logic                       i_nrst,
    input wire logic                       i_output_enable_n,
    input wire logic                       o_clk_enable,
    input wire logic                       o_output_override_enable,
    input wire logic [ocr_pkg::FAST_W-1:0] o_fast_output_divider,
    input wire logic [ocr_pkg::P2_W-1:0]   o_power_of_two_divider,
    input wire logic [5:0]                 o_power_of_two_ratio,
    input wire logic                       o_calibration_bypass,
    input wire logic                       o_calibration_start,
    input wire logic                       o_calibration_busy,
    input wire logic [ocr_pkg::FINE_W-1:0] o_fine_frequency_offset,
    input wire logic                       o_fine_offset_load,
    input wire logic                       o_device_reset,
    input wire logic [ocr_pkg::PAGE_W-1:0] o_page
);
    import ocr_pkg::*;
    logic [31:0] busy_cnt;
    // long busy run is counted, a repetition could never reach it
    always_ff @(posedge i_clk_sys) begin
        if (!i_nrst || !o_calibration_busy)
            busy_cnt <= 32'h0;
        else
            busy_cnt <= busy_cnt + 32'h1;
    end
    function automatic logic [5:0] ratio_of(input logic [2:0] c);
        return (c > 3'h4) ? 6'h20 : (6'h01 << c);
    endfunction
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_nrst);
    property p_ovr_off;
        !o_output_override_enable |=> !o_clk_enable;
    endproperty
    a_ovr_off: assert property (p_ovr_off)
        else $error("clock on while off");
    property p_pin_on;
        (o_output_override_enable && !i_output_enable_n) [*4]
            |=> o_clk_enable;
    endproperty
    a_pin_on: assert property (p_pin_on)
        else $error("pin enable ignored");
    property p_pin_off; i_output_enable_n [*4] |=> !o_clk_enable; endproperty
    a_pin_off: assert property (p_pin_off)
        else $error("pin disable ignored");
    property p_ratio;
        1'b1 |=> o_power_of_two_ratio
            == ratio_of($past(o_power_of_two_divider));
    endproperty
    a_ratio: assert property (p_ratio) else $error("ratio decode wrong");
    property p_fine_apply;
        $changed(o_fine_frequency_offset) |-> o_fine_offset_load
            || $past(o_fine_offset_load) || $past(o_device_reset);
    endproperty
    a_fine_apply: assert property (p_fine_apply)
        else $error("offset moved");
    property p_fine_step;
        o_fine_offset_load |=> !o_fine_offset_load
            && $stable(o_fine_frequency_offset);
    endproperty
    a_fine_step: assert property (p_fine_step)
        else $error("offset glitch");
    property p_cal_start;
        o_calibration_start |-> !o_calibration_bypass
            ##1 (!o_calibration_start && o_calibration_busy);
    endproperty
    a_cal_start: assert property (p_cal_start)
        else $error("bad cal start");
    property p_busy_len;
        $fell(o_calibration_busy) && !$past(o_device_reset)
            |-> busy_cnt == CAL_CYCLES;
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy length");
    property p_busy_max;
        o_calibration_busy |-> busy_cnt < CAL_CYCLES;
    endproperty
    a_busy_max: assert property (p_busy_max)
        else $error("busy too long");
    property p_soft_rst;
        o_device_reset |=> !o_device_reset && o_output_override_enable
            && o_fast_output_divider == RST_FAST && o_page == 2'h0;
    endproperty
    a_soft_rst: assert property (p_soft_rst) else $error("soft reset");
    c_cal: cover property (o_calibration_start);
    c_load: cover property (o_fine_offset_load);
    c_rst: cover property (o_device_reset);
endmodule

// >>> verification/ocr_host_model.sv
// serial bus host model driving the clock and data lines
`timescale 1ns/1ns
module ocr_host_model (
    output logic     o_scl,
    output logic     o_sda_low,
    input wire logic i_sda
);
    // clock stands high between frames, data released
    initial begin
        o_scl = 1'b1;
        o_sda_low = 1'b0;
    end
    // one 125 ns bit; data moves only while the clock is low
    task automatic bit_io(input logic b, output logic r);
        o_scl = 1'b0;
        #30 o_sda_low = !b;
        #30 o_scl = 1'b1;
        #40 r = i_sda;
        #25;
    endtask
    // s=1 gives a start, s=0 a stop
    task automatic cond(input logic s);
        o_scl = 1'b0;
        #30 o_sda_low = !s;
        #30 o_scl = 1'b1;
        #30 o_sda_low = s;
        #30;
    endtask
    task automatic put(input logic [7:0] d, output logic nack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], r);
        bit_io(1'b1, nack);
    endtask
    task automatic wr(input logic [6:0] dv, input logic [7:0] a, d,
                      output logic nack);
        logic [2:0] n;
        cond(1'b1);
        put({dv, 1'b0}, n[0]);
        put(a, n[1]);
        put(d, n[2]);
        cond(1'b0);
        nack = |n;
    endtask
    // three bytes in one frame, low byte first, pointer auto-increments
    task automatic wr3(input logic [6:0] dv, input logic [7:0] a,
                       input logic [23:0] d, output logic nack);
        logic [4:0] n;
        cond(1'b1);
        put({dv, 1'b0}, n[0]);
        put(a, n[1]);
        put(d[7:0], n[2]);
        put(d[15:8], n[3]);
        put(d[23:16], n[4]);
        cond(1'b0);
        nack = |n;
    endtask
    task automatic rd(input logic [6:0] dv, input logic [7:0] a,
                      output logic [7:0] d, output logic nack);
        logic [2:0] n;
        cond(1'b1);
        put({dv, 1'b0}, n[0]);
        put(a, n[1]);
        cond(1'b1);
        put({dv, 1'b1}, n[2]);
        for (int i = 7; i >= 0; i--)
            bit_io(1'b1, d[i]);
        bit_io(1'b1, nack);
        cond(1'b0);
        nack = |n;
    endtask
endmodule

// >>> verification/ocr_regs_test.sv
// self-checking bench for the oscillator register bank
`timescale 1ns/1ns
module ocr_regs_test;
    import ocr_pkg::*;
    localparam int unsigned CAL  = 50;
    localparam logic [6:0]  DEV  = 7'h55;
    localparam logic [7:0]  PART = 8'h3c; // arbitrary part code
    localparam logic [7:0]  RA [10] = '{8'h00, 8'h07, 8'h11, 8'h17, 8'h18,
                                        8'h1a, 8'h1e, 8'h1f, 8'he7, 8'hff};
    localparam logic [7:0]  RV [10] = '{PART, 8'h00, 8'h01, 8'h54, 8'h00,
                                        8'h00, 8'h64, 8'h00, 8'h00, 8'h00};
    localparam logic [5:0]  RT [8]  = '{6'h01, 6'h02, 6'h04, 6'h08,
                                        6'h10, 6'h20, 6'h20, 6'h20};
    localparam logic [7:0]  FB [6]  = '{8'h2a, 8'he6, 8'h56, 8'he7,
                                        8'h47, 8'hff};
    logic        i_clk_sys = 1'b0;
    logic        i_nrst = 1'b0;
    logic        i_output_enable_n = 1'b0;
    logic        i_scl, sda_low, o_sda_out, o_sda_oe, o_clk_enable;
    logic        o_output_override_enable, o_calibration_bypass;
    logic        o_calibration_start, o_calibration_busy;
    logic        o_fine_offset_load, o_device_reset, n;
    logic [10:0] o_fast_output_divider;
    logic [2:0]  o_power_of_two_divider;
    logic [5:0]  o_power_of_two_ratio;
    logic [42:0] o_feedback_ratio;
    logic [23:0] o_fine_frequency_offset;
    logic [1:0]  o_page;
    wire logic   i_sda;
    int          failures = 0, n_tests = 0, n_start = 0, n_rst = 0, n_busy = 0;
    // open drain line with pull-up
    assign i_sda = !(sda_low || o_sda_oe);
    always #5 i_clk_sys = ~i_clk_sys;
    always @(posedge i_clk_sys) begin
        n_start += int'(o_calibration_start === 1'b1);
        n_rst += int'(o_device_reset === 1'b1);
        n_busy += int'(o_calibration_busy === 1'b1);
    end
    ocr_host_model u_host (.o_scl(i_scl), .o_sda_low(sda_low), .i_sda);
    ocr_regs #(.BUS_ADDR(DEV), .PART_CODE(PART), .CAL_CYCLES(CAL)) u_dut (
        .i_clk_sys, .i_nrst, .i_scl, .i_sda, .o_sda_out, .o_sda_oe,
        .i_output_enable_n, .o_clk_enable, .o_output_override_enable,
        .o_fast_output_divider, .o_power_of_two_divider,
        .o_power_of_two_ratio, .o_feedback_ratio, .o_calibration_bypass,
        .o_calibration_start, .o_calibration_busy, .o_fine_frequency_offset,
        .o_fine_offset_load, .o_device_reset, .o_page);
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge i_clk_sys);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic nk;
        u_host.wr(DEV, a, d, nk);
        chk(64'(nk), 64'h0);
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        logic       nk;
        u_host.rd(DEV, a, d, nk);
        chk(64'({nk, d}), 64'({1'b0, e}));
    endtask
    task automatic test_done();
        $display("checks %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        tick(3);
        i_nrst = 1'b1;
        tick(4);
        for (int k = 0; k < 10; k++)
            rc(RA[k], RV[k]);
        wr(ADDR_ID, 8'h12);
        rc(ADDR_ID, PART);
        wr(ADDR_FAST_LO, 8'ha6);
        wr(ADDR_PACKED, 8'hff);
        rc(ADDR_PACKED, 8'h77);
        chk(64'(o_fast_output_divider), 64'h7a6);
        for (int k = 0; k < 8; k++) begin
            wr(ADDR_PACKED, {1'b0, k[2:0], 4'h7});
            chk(64'(o_power_of_two_ratio), 64'(RT[k]));
            chk(64'(o_power_of_two_divider), 64'(k[2:0]));
        end
        for (int k = 0; k < 6; k++)
            wr(ADDR_FB0 + 8'(k), FB[k]);
        rc(ADDR_FB_TOP, 8'h07);
        chk(64'(o_feedback_ratio), 64'h747e756e62a);
        wr(ADDR_OUT, 8'hfe);
        rc(ADDR_OUT, 8'h00);
        tick(2);
        chk(64'(o_clk_enable), 64'h0);
        wr(ADDR_OUT, 8'h01);
        tick(5);
        chk(64'(o_clk_enable), 64'h1);
        i_output_enable_n = 1'b1;
        tick(5);
        chk(64'(o_clk_enable), 64'h0);
        i_output_enable_n = 1'b0;
        wr(ADDR_FINE0, 8'h56);
        wr(ADDR_FINE1, 8'h34);
        chk(64'(o_fine_frequency_offset), 64'h0);
        rc(ADDR_FINE1, 8'h34);
        wr(ADDR_FINE2, 8'h92);
        chk(64'(o_fine_frequency_offset), 64'h923456);
        u_host.wr3(DEV, ADDR_FINE0, 24'h12abcd, n);
        chk(64'(n), 64'h0);
        chk(64'(o_fine_frequency_offset), 64'h12abcd);
        u_host.wr(7'h2a, ADDR_FAST_LO, 8'h11, n);
        chk(64'(n), 64'h1);
        wr(ADDR_PAGE, 8'h01);
        chk(64'(o_page), 64'h1);
        rc(ADDR_FAST_LO, 8'h00);
        wr(ADDR_FAST_LO, 8'h11);
        rc(ADDR_PAGE, 8'h01);
        wr(ADDR_PAGE, 8'h00);
        rc(ADDR_FAST_LO, 8'ha6);
        wr(ADDR_BYPASS, 8'h01);
        chk(64'(o_calibration_bypass), 64'h0);
        wr(ADDR_CTRL, 8'h08);
        for (int k = 0; k < 400 && o_calibration_busy !== 1'b0; k++)
            tick(1);
        if (o_calibration_busy !== 1'b0) begin
            failures++;
            test_done();
        end
        chk(64'(n_busy), 64'(CAL));
        rc(ADDR_CTRL, 8'h00);
        wr(ADDR_BYPASS, 8'h81);
        wr(ADDR_CTRL, 8'h08);
        tick(5);
        chk(64'(n_start), 64'h1);
        wr(ADDR_CTRL, 8'h80);
        tick(3);
        chk(64'(n_rst), 64'h1);
        rc(ADDR_FAST_LO, 8'h54);
        rc(ADDR_CTRL, 8'h00);
        test_done();
    end
endmodule
bind ocr_regs ocr_regs_assertions #(.CAL_CYCLES(CAL_CYCLES)) u_chk (
    .i_clk_sys, .i_nrst, .i_output_enable_n, .o_clk_enable,
    .o_output_override_enable, .o_fast_output_divider,
    .o_power_of_two_divider, .o_power_of_two_ratio, .o_calibration_bypass,
    .o_calibration_start, .o_calibration_busy, .o_fine_frequency_offset,
    .o_fine_offset_load, .o_device_reset, .o_page);
